// ### core/trig_step_pkg.sv
// Package with register map, reset values and field positions of the step delay block.
package trig_step_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] SDLIM_OFS   = 8'h04;
	localparam logic [7:0] C0LIM_OFS   = 8'h08;
	localparam logic [7:0] STEPCNT_OFS = 8'h0c;
	localparam logic [7:0] DONECNT_OFS = 8'h10;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          ENABLE_BIT  = 0;
	localparam int          START_BIT   = 1;
	localparam int          RUN_BIT     = 2;
	localparam int          LIMIT_W     = 16;
	localparam logic [15:0] LIMIT_RST   = 16'h0000;
	localparam logic [1:0]  CTRL_RST    = 2'h0;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [15:0] BASE_DELAY  = 16'h0001;

endpackage

// ### core/limit_reg.sv
// Byte-writable limit register with a write lock.
`timescale 1ns/100ps
`default_nettype none
module limit_reg
	import trig_step_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             we_i,
	input  wire logic             lock_i,
	input  wire logic [1:0]       strb_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output logic      [WIDTH-1:0] value_o
);

	// ------------------------------------------------------------
	// Byte lane update
	// ------------------------------------------------------------
	wire             accept = we_i & ~lock_i;
	wire [WIDTH-1:0] lane_mask = {{(WIDTH-8){strb_i[1]}}, {8{strb_i[0]}}};
	wire [WIDTH-1:0] next_value = (value_o & ~lane_mask) | (wdata_i & lane_mask);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			value_o <= LIMIT_RST[WIDTH-1:0];
		else if (accept)
			value_o <= next_value;
	end

endmodule
`default_nettype wire

// ### core/step_timer.sv
// Step duration counter that ends each step after the limit plus one clock.
`timescale 1ns/100ps
`default_nettype none
module step_timer
	import trig_step_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             run_i,
	input  wire logic [WIDTH-1:0] limit_i,
	output logic      [WIDTH-1:0] count_o,
	output logic                  done_o
);

	// ------------------------------------------------------------
	// Count and completion
	// ------------------------------------------------------------
	assign done_o = run_i & (count_o == limit_i);

	wire [WIDTH-1:0] next_count = (!run_i || done_o) ? COUNT_RST[WIDTH-1:0] : WIDTH'(count_o + 1'b1);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			count_o <= COUNT_RST[WIDTH-1:0];
		else
			count_o <= next_count;
	end

endmodule
`default_nettype wire

// ### core/trig_step_delay.sv
// Step delay and counter 0 limit registers of the trigger sequencer, on APB.
//
// Overview of operation
// RULE1 - Sixteen-bit read/write step delay limit, zero after reset.
// RULE2 - Stored limit sets the extra clocks from step start to step end.
// RULE3 - One base clock is added, so a step lasts limit plus one clocks.
// RULE4 - Step delay limit ignores writes while enable and start are both set.
// RULE5 - Separate read/write counter 0 limit register, zero after reset.
// RULE6 - Counter 0 limit is 16 bits, loop count or general counter limit.
// RULE7 - Count clocks per step, flag completion at limit plus one, then restart.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module trig_step_delay
	import trig_step_pkg::*;
#(
	parameter int WIDTH = LIMIT_W
)
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [7:0]       paddr_i,
	input  wire logic [31:0]      pwdata_i,
	input  wire logic [3:0]       pstrb_i,
	output logic      [31:0]      prdata_o,
	output logic                  pready_o,
	output logic                  pslverr_o,
	output logic                  sequencer_enable_o,
	output logic                  sequencer_start_run_o,
	output logic      [WIDTH-1:0] step_delay_limit_o,
	output logic      [WIDTH-1:0] loop_counter0_limit_o,
	output logic                  step_done_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic             sequencer_enable;
	logic             sequencer_start_run;
	logic [WIDTH-1:0] step_delay_limit;
	logic [WIDTH-1:0] loop_counter0_limit;
	logic [WIDTH-1:0] step_count;
	logic [15:0]      done_count;
	logic             step_done;
	logic [31:0]      rdata;
	logic             rerr;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	wire setup_ph  = psel_i & ~penable_i;
	wire access_ph = psel_i & penable_i;
	wire wr_cycle  = access_ph & pwrite_i;
	wire sel_ctrl  = hit(paddr_i, CTRL_OFS);
	wire sel_sdl   = hit(paddr_i, SDLIM_OFS);
	wire sel_c0    = hit(paddr_i, C0LIM_OFS);
	wire sel_cnt   = hit(paddr_i, STEPCNT_OFS);
	wire sel_done  = hit(paddr_i, DONECNT_OFS);
	wire mapped    = sel_ctrl | sel_sdl | sel_c0 | sel_cnt | sel_done;
	wire run       = sequencer_enable & sequencer_start_run;
	wire sdl_lock  = run;
	wire wr_ctrl   = wr_cycle & sel_ctrl & pstrb_i[0];
	wire wr_sdl    = wr_cycle & sel_sdl;
	wire wr_c0     = wr_cycle & sel_c0;
	wire wr_done   = wr_cycle & sel_done;

	wire [31:0] ctrl_word = {29'h0, run, sequencer_start_run, sequencer_enable};
	wire [31:0] next_rdata = sel_ctrl ? ctrl_word
		: sel_sdl  ? {16'h0000, step_delay_limit}
		: sel_c0   ? {16'h0000, loop_counter0_limit}
		: sel_cnt  ? {16'h0000, step_count}
		: sel_done ? {16'h0000, done_count}
		: 32'h0000_0000;

	// ------------------------------------------------------------
	// APB answer, zero wait states
	// ------------------------------------------------------------
	assign pready_o  = 1'b1;
	assign prdata_o  = rdata;
	assign pslverr_o = access_ph & rerr;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rdata <= 32'h0000_0000;
			rerr  <= 1'b0;
		end
		else if (setup_ph)
		begin
			rdata <= pwrite_i ? 32'h0000_0000 : next_rdata;
			rerr  <= ~mapped;
		end
	end

	// ------------------------------------------------------------
	// Control bits
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			{sequencer_start_run, sequencer_enable} <= CTRL_RST;
		else if (wr_ctrl)
			{sequencer_start_run, sequencer_enable} <= {pwdata_i[START_BIT], pwdata_i[ENABLE_BIT]};
	end

	// ------------------------------------------------------------
	// Limit registers
	// ------------------------------------------------------------
	limit_reg #(
		.WIDTH (WIDTH)
	) u_sdl (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.we_i    (wr_sdl),
		.lock_i  (sdl_lock),  // RULE4
		.strb_i  (pstrb_i[1:0]),
		.wdata_i (pwdata_i[WIDTH-1:0]),
		.value_o (step_delay_limit)  // RULE1
	);

	limit_reg #(
		.WIDTH (WIDTH)
	) u_c0 (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.we_i    (wr_c0),
		.lock_i  (1'b0),
		.strb_i  (pstrb_i[1:0]),
		.wdata_i (pwdata_i[WIDTH-1:0]),
		.value_o (loop_counter0_limit)  // RULE5
	);

	// ------------------------------------------------------------
	// Step timing
	// ------------------------------------------------------------
	step_timer #(
		.WIDTH (WIDTH)
	) u_timer (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.run_i   (run),
		.limit_i (step_delay_limit),  // RULE2
		.count_o (step_count),  // RULE3
		.done_o  (step_done)  // RULE7
	);

	wire [15:0] next_done_count = wr_done ? {15'h0000, step_done}
		: step_done ? 16'(done_count + 1'b1)
		: done_count;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			done_count <= COUNT_RST;
		else
			done_count <= next_done_count;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sequencer_enable_o    = sequencer_enable;
	assign sequencer_start_run_o = sequencer_start_run;
	assign step_delay_limit_o    = step_delay_limit;
	assign loop_counter0_limit_o = loop_counter0_limit;  // RULE6
	assign step_done_o           = step_done;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sdl_write_a: assert property (  // RULE1
		wr_sdl && !sdl_lock && pstrb_i[1:0] == 2'h3
		|=> step_delay_limit == $past(pwdata_i[15:0]))
		else $error("Step delay limit write not stored.");

	step_length_a: assert property (  // RULE2
		run && !step_done |=> step_count == 16'($past(step_count) + 1'b1))
		else $error("Step count did not advance.");

	base_clock_a: assert property (  // RULE3
		(step_done && run && step_delay_limit == 16'h0001) ##1 run
		|-> !step_done ##1 (step_done || !run))
		else $error("Step length is not limit plus one.");

	zero_limit_a: assert property (  // RULE3
		step_done && step_delay_limit == 16'h0000 ##1 run |-> step_done)
		else $error("Zero limit step is not one clock.");

	sdl_lock_a: assert property (  // RULE4
		sdl_lock |=> $stable(step_delay_limit))
		else $error("Locked step delay limit changed.");

	c0_write_a: assert property (  // RULE5
		wr_c0 && pstrb_i[1:0] == 2'h3
		|=> loop_counter0_limit == $past(pwdata_i[15:0]))
		else $error("Counter 0 limit write not stored.");

	c0_read_a: assert property (  // RULE6
		access_ph && !pwrite_i && sel_c0
		|-> prdata_o == {16'h0000, loop_counter0_limit} && loop_counter0_limit_o == loop_counter0_limit)
		else $error("Counter 0 limit readback wrong.");

	restart_a: assert property (  // RULE7
		step_done && run |=> step_count == 16'h0000 && (done_count != $past(done_count) || $past(wr_done)))
		else $error("Step count did not restart.");

	idle_done_a: assert property (  // RULE7
		!run |-> !step_done ##1 (step_count == 16'h0000))
		else $error("Step completion while stopped.");

	unmapped_a: assert property (
		access_ph && !mapped |-> pslverr_o && pready_o)
		else $error("Unmapped access not flagged.");

	mapped_err_a: assert property (
		access_ph && mapped
		|-> !pslverr_o)
		else $error("Mapped access flagged as error.");

	unmapped_read_a: assert property (
		access_ph && !pwrite_i && !mapped
		|-> prdata_o == 32'h0000_0000)
		else $error("Unmapped read returned data.");

	sdl_low_a: assert property (  // RULE1
		wr_sdl && !sdl_lock && pstrb_i[1:0] == 2'h1
		|=> step_delay_limit == {$past(step_delay_limit[15:8]), $past(pwdata_i[7:0])})
		else $error("Step delay limit low byte write wrong.");

	sdl_high_a: assert property (  // RULE1
		wr_sdl && !sdl_lock && pstrb_i[1:0] == 2'h2
		|=> step_delay_limit == {$past(pwdata_i[15:8]), $past(step_delay_limit[7:0])})
		else $error("Step delay limit high byte write wrong.");

	sdl_nostrb_a: assert property (  // RULE1
		wr_sdl && pstrb_i[1:0] == 2'h0
		|=> $stable(step_delay_limit))
		else $error("Step delay limit changed without strobes.");

	sdl_read_a: assert property (  // RULE1
		access_ph && !pwrite_i && sel_sdl
		|-> prdata_o == {16'h0000, step_delay_limit})
		else $error("Step delay limit readback wrong.");

	ctrl_write_a: assert property (  // RULE4
		wr_ctrl
		|=> {sequencer_start_run, sequencer_enable} == $past(pwdata_i[1:0]))
		else $error("Control write not stored.");

	ctrl_nostrb_a: assert property (  // RULE4
		wr_cycle && sel_ctrl && !pstrb_i[0]
		|=> $stable({sequencer_start_run, sequencer_enable}))
		else $error("Control changed without strobe.");

	ctrl_read_a: assert property (  // RULE4
		access_ph && !pwrite_i && sel_ctrl
		|-> prdata_o == {29'h0, run, sequencer_start_run, sequencer_enable})
		else $error("Control readback wrong.");

	c0_low_a: assert property (  // RULE5
		wr_c0 && pstrb_i[1:0] == 2'h1
		|=> loop_counter0_limit == {$past(loop_counter0_limit[15:8]), $past(pwdata_i[7:0])})
		else $error("Counter 0 limit low byte write wrong.");

	c0_high_a: assert property (  // RULE6
		wr_c0 && pstrb_i[1:0] == 2'h2
		|=> loop_counter0_limit == {$past(pwdata_i[15:8]), $past(loop_counter0_limit[7:0])})
		else $error("Counter 0 limit high byte write wrong.");

	count_start_a: assert property (  // RULE7
		$rose(run)
		|-> step_count == 16'h0000)
		else $error("Step count not zero at start.");

	done_count_a: assert property (  // RULE7
		step_done && !wr_done
		|=> done_count == 16'($past(done_count) + 1'b1))
		else $error("Completed step not counted.");

	done_clear_a: assert property (  // RULE7
		wr_done && !step_done
		|=> done_count == 16'h0000)
		else $error("Completed step count not cleared.");

	done_set_a: assert property (  // RULE7
		wr_done && step_done
		|=> done_count == 16'h0001)
		else $error("Step lost against count clear.");

	// ------------------------------------------------------------
	// Covers
	// ------------------------------------------------------------
	step_done_c: cover property (step_done ##1 run [*2] ##1 step_done);
	locked_write_c: cover property (wr_sdl && sdl_lock);
	unmapped_c: cover property (access_ph && !mapped);
	c0_write_c: cover property (wr_c0 ##3 access_ph && !pwrite_i && sel_c0);
	run_start_c: cover property ($rose(run) ##[1:20] step_done);

endmodule
`default_nettype wire

// ### sim/test_trig_step_delay.sv
// Self-checking testbench for the step delay and counter 0 limit registers.
`timescale 1ns/100ps
`default_nettype none
module test_trig_step_delay
	import trig_step_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [15:0] e;} row_s;
	logic        clk_i     = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [7:0]  paddr_i   = 8'h00;
	logic [31:0] pwdata_i  = 32'h0;
	logic [3:0]  pstrb_i   = 4'h0;
	wire  [31:0] prdata_o;
	wire         pready_o;
	wire         pslverr_o;
	wire         sequencer_enable_o;
	wire         sequencer_start_run_o;
	wire  [15:0] step_delay_limit_o;
	wire  [15:0] loop_counter0_limit_o;
	wire         step_done_o;
	int          fails      = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	logic [31:0] rd;
	logic        er;
	row_s        rows [6];

	trig_step_delay dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.sequencer_enable_o(sequencer_enable_o), .sequencer_start_run_o(sequencer_start_run_o),
		.step_delay_limit_o(step_delay_limit_o), .loop_counter0_limit_o(loop_counter0_limit_o),
		.step_done_o(step_done_o));

	// ------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------
	always #50 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// ------------------------------------------------------------
	// APB master
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		pstrb_i   <= s;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			close_out();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(nm, rd, exp);
	endtask

	// Measures the clocks from one step completion to the next.
	task automatic period(input int exp, input string nm);
		int n;
		n = 0;
		@(negedge clk_i);
		while (step_done_o !== 1'b1 && n < 100)
		begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (step_done_o !== 1'b1 && n < 100);
		chk(nm, n, exp);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rows[0] = '{SDLIM_OFS, 32'h0000a5c3, 4'hf, 16'ha5c3};
		rows[1] = '{SDLIM_OFS, 32'h12345678, 4'h1, 16'ha578};
		rows[2] = '{SDLIM_OFS, 32'h00003c00, 4'h2, 16'h3c78};
		rows[3] = '{C0LIM_OFS, 32'hffffffff, 4'hf, 16'hffff};
		rows[4] = '{C0LIM_OFS, 32'h00001200, 4'h2, 16'h12ff};
		rows[5] = '{C0LIM_OFS, 32'h000000a1, 4'h1, 16'h12a1};
		repeat (3) @(posedge clk_i);
		chk("sdlim_rst", step_delay_limit_o, 32'h0);
		rstn_i <= 1'b1;
		rdc(SDLIM_OFS, 32'h0, "sdlim_por");
		rdc(C0LIM_OFS, 32'h0, "c0lim_por");
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
			rdc(rows[i].a, {16'h0, rows[i].e}, "row_read");
		end
		chk("c0lim_port", loop_counter0_limit_o, 32'h12a1);
		apb(1'b1, SDLIM_OFS, 32'hffff, 4'h0);
		rdc(SDLIM_OFS, 32'h3c78, "sdlim_no_strobe");
		apb(1'b1, CTRL_OFS, 32'h3, 4'h0);
		rdc(CTRL_OFS, 32'h0, "ctrl_no_strobe");
		apb(1'b1, 8'h20, 32'h5, 4'hf);
		chk("unmapped_err", er, 1'b1);
		rdc(8'h20, 32'h0, "unmapped_read");
		chk("unmapped_read_err", er, 1'b1);
		apb(1'b1, SDLIM_OFS, 32'h2, 4'hf);
		apb(1'b1, CTRL_OFS, 32'h3, 4'h1);
		@(negedge clk_i);
		chk("run_bits", {sequencer_enable_o, sequencer_start_run_o}, 2'b11);
		period(3, "step_len2");
		period(3, "step_len2_again");
		apb(1'b1, SDLIM_OFS, 32'h7, 4'hf);
		rdc(SDLIM_OFS, 32'h2, "sdlim_locked");
		chk("sdlim_port_locked", step_delay_limit_o, 32'h2);
		apb(1'b1, C0LIM_OFS, 32'h55, 4'hf);
		rdc(C0LIM_OFS, 32'h55, "c0lim_running");
		apb(1'b1, CTRL_OFS, 32'h1, 4'h1);
		apb(1'b1, SDLIM_OFS, 32'h0, 4'hf);
		rdc(SDLIM_OFS, 32'h0, "sdlim_unlocked");
		apb(1'b1, CTRL_OFS, 32'h3, 4'h1);
		period(1, "step_len0");
		apb(1'b1, SDLIM_OFS, 32'h5, 4'hf);
		apb(1'b1, CTRL_OFS, 32'h2, 4'h1);
		apb(1'b1, SDLIM_OFS, 32'h5, 4'hf);
		apb(1'b1, CTRL_OFS, 32'h3, 4'h1);
		period(6, "step_len5");
		apb(1'b1, CTRL_OFS, 32'h0, 4'h1);
		apb(1'b1, SDLIM_OFS, 32'h1, 4'hf);
		apb(1'b1, CTRL_OFS, 32'h3, 4'h1);
		rdc(CTRL_OFS, 32'h7, "ctrl_running");
		period(2, "step_len1");
		apb(1'b1, CTRL_OFS, 32'h0, 4'h1);
		repeat (8)
		begin
			@(negedge clk_i);
			chk("no_step_idle", step_done_o, 1'b0);
		end
		apb(1'b1, STEPCNT_OFS, 32'h9, 4'hf);
		chk("count_ro_err", er, 1'b0);
		rdc(STEPCNT_OFS, 32'h0, "count_idle");
		apb(1'b1, DONECNT_OFS, 32'h0, 4'hf);
		rdc(DONECNT_OFS, 32'h0, "done_cleared");
		apb(1'b1, CTRL_OFS, 32'h3, 4'h1);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		@(negedge clk_i);
		chk("run_in_reset", {sequencer_enable_o, sequencer_start_run_o, step_done_o}, 3'h0);
		@(posedge clk_i);
		rstn_i <= 1'b1;
		rdc(SDLIM_OFS, 32'h0, "sdlim_rereset");
		rdc(C0LIM_OFS, 32'h0, "c0lim_rereset");
		rdc(CTRL_OFS, 32'h0, "ctrl_rereset");
		close_out();
	end
endmodule
`default_nettype wire
